// File: include/spdif_in_pkg.sv
// Constants for the serial audio input stage of a biphase transmitter.
// Assumes a single 100 MHz system clock; all link pins arrive asynchronously.
`default_nettype none
package spdif_in_pkg;
  // Framing formats, I2S is the reset default
  typedef enum logic [1:0] {
    FMT_I2S   = 2'h0,
    FMT_LEFT  = 2'h1,
    FMT_RIGHT = 2'h2
  } frame_fmt_t;
  // Word width codes
  typedef enum logic [1:0] {
    W16 = 2'h0,
    W18 = 2'h1,
    W20 = 2'h2,
    W24 = 2'h3
  } word_width_t;
  localparam int unsigned MAX_BITS      = 24;
  localparam int unsigned FRAME_BITS    = 32;     // Serial clocks per channel slot at 64 per frame
  localparam logic [5:0]  I2S_DELAY     = 6'h01;
  localparam logic [5:0]  LJ_DELAY      = 6'h00;
  localparam logic [5:0]  RJ_DELAY_16   = 6'h10;
  localparam logic [5:0]  RJ_DELAY_18   = 6'h0e;
  localparam logic [5:0]  RJ_DELAY_20   = 6'h0c;
  localparam logic [5:0]  RJ_DELAY_24   = 6'h08;
  localparam logic [4:0]  BITS_16       = 5'h10;
  localparam logic [4:0]  BITS_18       = 5'h12;
  localparam logic [4:0]  BITS_20       = 5'h14;
  localparam logic [4:0]  BITS_24       = 5'h18;
  localparam int unsigned OSR_LOW       = 256;
  localparam int unsigned OSR_HIGH      = 384;
  localparam int unsigned BIPHASE_PER_FS = 128;   // Biphase cells per frame
  localparam int unsigned DIV_LOW       = OSR_LOW / BIPHASE_PER_FS;
  localparam int unsigned DIV_HIGH      = OSR_HIGH / BIPHASE_PER_FS;
  localparam logic [1:0]  DIV_LOW_M1    = 2'(DIV_LOW - 1);
  localparam logic [1:0]  DIV_HIGH_M1   = 2'(DIV_HIGH - 1);
endpackage : spdif_in_pkg
`default_nettype wire

// File: include/sample_if.sv
// Sample handshake between the deserialiser and the two-entry buffer.
// Assumes both ends share one clock.
`default_nettype none
interface sample_if;
  logic                 valid;
  logic                 ready;
  logic                 right;
  logic [23:0]          data;
  modport src  (output valid, output right, output data, input ready);
  modport sink (input valid, input right, input data, output ready);
endinterface : sample_if
`default_nettype wire

// File: verilog/skid_buffer2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes the writer holds data while valid and not ready.
`default_nettype none
module skid_buffer2 #(
  parameter int unsigned WIDTH = 25
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  initial
  begin
    if (WIDTH < 1) $error("WIDTH too small");
  end

  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic             wp_q, wp_d, rp_q, rp_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  ////////////////////////////////////////////////////////////////
  // Pointers and count; full stalls the writer
  always_comb
  begin
    in_ready  = (cnt_q != 2'h2);
    out_valid = (cnt_q != 2'h0);
    out_data  = mem_q[rp_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    mem_d     = mem_q;
    wp_d      = wp_q;
    rp_d      = rp_q;
    cnt_d     = cnt_q;
    if (push)
    begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop)
      rp_d = ~rp_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
      mem_q <= '{default: '0};
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  a_no_overflow: assert property (@(posedge clock) disable iff (rst)
    cnt_q == 2'h2 |-> !in_ready)
    else $error("buffer accepts while full");
endmodule : skid_buffer2
`default_nettype wire

// File: verilog/spdif_serial_in.sv
// Serial audio input stage and biphase clock divider of a biphase transmitter.
// Assumes serial clock, frame sync, data and the oversample clock are async pins
// sampled by the 100 MHz system clock, each much slower than it.
// Function
// - Data and frame sync sampled on serial clock rising edge, all formats.
// - Right-justified: frame sync high for left, low for right.
// - Right-justified MSB delay 16, 14, 12, 8 clocks for 16-24 bit widths.
// - Right-justified at 64 clocks per frame: LSB ends at next transition.
// - I2S is default; frame sync low for left, high for right.
// - I2S MSB comes one serial clock after frame sync transition.
// - Left-justified: frame sync high for left, low for right.
// - Left-justified MSB coincides with frame sync transition.
// - Biphase clock derived by dividing the oversample transmit clock.
// - Oversample clock is 256 or 384 times frame rate; divider matches.
// - Three formats accepted, word widths 16, 18, 20 or 24 bits.
`default_nettype none
module spdif_serial_in (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        serial_clock,
  input  wire logic                        frame_sync,
  input  wire logic                        serial_data,
  input  wire logic                        oversample_tx_clock,
  input  wire spdif_in_pkg::frame_fmt_t    fmt,
  input  wire spdif_in_pkg::word_width_t   width,
  input  wire logic                        osr_384,
  output logic                             sample_valid,
  input  wire logic                        sample_ready,
  output logic                             sample_right,
  output logic [23:0]                      sample_data,
  output logic                             biphase_tick,
  output logic                             overrun
);
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage read only by the second
  logic [2:0] s1_q, s2_q, s3_q;
  logic       os1_q;
  logic       os2_q, os3_q;

  always_ff @(posedge clock)
  begin
    s1_q  <= {serial_clock, frame_sync, serial_data};
    s2_q  <= s1_q;
    s3_q  <= s2_q;
    os1_q <= oversample_tx_clock;
    os2_q <= os1_q;
    os3_q <= os2_q;
  end

  logic sclk_s, fs_s, sd_s, sclk_rise, os_rise;
  always_comb
  begin
    sclk_s    = s2_q[2];
    fs_s      = s2_q[1];
    sd_s      = s2_q[0];
    sclk_rise = sclk_s && !s3_q[2];
    os_rise   = os2_q && !os3_q;
  end

  ////////////////////////////////////////////////////////////////
  // Per-format delay and width selection
  logic [5:0] delay;
  logic [4:0] nbits;
  logic       fs_left;
  always_comb
  begin
    case (width)
      spdif_in_pkg::W16: nbits = spdif_in_pkg::BITS_16;
      spdif_in_pkg::W18: nbits = spdif_in_pkg::BITS_18;
      spdif_in_pkg::W20: nbits = spdif_in_pkg::BITS_20;
      default:           nbits = spdif_in_pkg::BITS_24;
    endcase
    case (fmt)
      spdif_in_pkg::FMT_RIGHT:
      begin
        // RJ delay table, LSB lands at slot end
        case (width)
          spdif_in_pkg::W16: delay = spdif_in_pkg::RJ_DELAY_16;
          spdif_in_pkg::W18: delay = spdif_in_pkg::RJ_DELAY_18;
          spdif_in_pkg::W20: delay = spdif_in_pkg::RJ_DELAY_20;
          default:           delay = spdif_in_pkg::RJ_DELAY_24;
        endcase
        fs_left = 1'b1;
      end
      spdif_in_pkg::FMT_LEFT:
      begin
        delay   = spdif_in_pkg::LJ_DELAY;
        fs_left = 1'b1;
      end
      default:
      begin
        // one clock delay, left while low
        delay   = spdif_in_pkg::I2S_DELAY;
        fs_left = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Slot tracking and shift register
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_SHIFT = 2'h2
  } state_t;

  state_t      st_q, st_d;
  logic        fs_prev_q, fs_prev_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [4:0]  got_q, got_d;
  logic [23:0] sh_q, sh_d;
  logic        chan_q, chan_d;
  logic        push, ovr_q, ovr_d;
  logic        fs_edge;
  sample_if    smp ();

  always_comb
  begin
    st_d      = st_q;
    fs_prev_d = fs_prev_q;
    cnt_d     = cnt_q;
    got_d     = got_q;
    sh_d      = sh_q;
    chan_d    = chan_q;
    push      = 1'b0;
    ovr_d     = ovr_q;
    fs_edge   = sclk_rise && (fs_s != fs_prev_q);
    if (sclk_rise)
    begin
      fs_prev_d = fs_s;
      // New slot on frame sync change; left-justified MSB is this very bit
      if (fs_edge)
      begin
        chan_d = (fs_s != fs_left);
        got_d  = 5'h0;
        sh_d   = '0;
        if (delay == 6'h00)
        begin
          sh_d  = {23'h0, sd_s};
          got_d = 5'h1;
          st_d  = ST_SHIFT;
        end
        else
        begin
          cnt_d = delay - 6'h1;
          st_d  = ST_WAIT;
        end
      end
      else
      begin
        case (st_q)
          ST_WAIT:
          begin
            if (cnt_q == 6'h0)
            begin
              sh_d  = {23'h0, sd_s};
              got_d = 5'h1;
              st_d  = ST_SHIFT;
            end
            else
              cnt_d = cnt_q - 6'h1;
          end
          ST_SHIFT:
          begin
            if (got_q < nbits)
            begin
              sh_d  = {sh_q[22:0], sd_s};
              got_d = got_q + 5'h1;
            end
          end
          default: st_d = ST_IDLE;
        endcase
      end
    end
    if (st_q == ST_SHIFT && got_q == nbits)
    begin
      push  = 1'b1;
      st_d  = fs_edge ? st_d : ST_IDLE;
      if (!smp.ready)
        ovr_d = 1'b1;
      if (!fs_edge)
        got_d = 5'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q      <= ST_IDLE;
      fs_prev_q <= 1'b0;
      cnt_q     <= 6'h0;
      got_q     <= 5'h0;
      sh_q      <= 24'h0;
      chan_q    <= 1'b0;
      ovr_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      fs_prev_q <= fs_prev_d;
      cnt_q     <= cnt_d;
      got_q     <= got_d;
      sh_q      <= sh_d;
      chan_q    <= chan_d;
      ovr_q     <= ovr_d;
    end
  end

  // Word is left-aligned so narrow widths keep their MSB at bit 23
  assign smp.valid = push;
  assign smp.right = chan_q;
  assign smp.data  = sh_q << (5'h18 - nbits);
  assign overrun   = ovr_q;

  skid_buffer2 #(.WIDTH(25)) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (smp.valid),
    .in_ready  (smp.ready),
    .in_data   ({smp.right, smp.data}),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  ({sample_right, sample_data})
  );

  ////////////////////////////////////////////////////////////////
  // Biphase clock divider on oversample clock edges
  logic [1:0] div_q, div_d, div_top;
  logic       tick_q, tick_d;
  always_comb
  begin
    div_top = osr_384 ? spdif_in_pkg::DIV_HIGH_M1 : spdif_in_pkg::DIV_LOW_M1;
    div_d   = div_q;
    tick_d  = 1'b0;
    if (os_rise)
    begin
      if (div_q >= div_top)
      begin
        div_d  = 2'h0;
        tick_d = 1'b1;
      end
      else
        div_d = div_q + 2'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      div_q  <= 2'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end
  assign biphase_tick = tick_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  // tick only after an oversample edge
  a_tick_cause: assert property (@(posedge clock) disable iff (rst)
    biphase_tick |-> $past(os_rise))
    else $error("biphase tick without oversample edge");
  a_div_range: assert property (@(posedge clock) disable iff (rst)
    div_q <= (osr_384 ? 2'h2 : 2'h1))
    else $error("divider out of range");
  // zero delay starts shifting at once
  a_lj_start: assert property (@(posedge clock) disable iff (rst)
    fs_edge && fmt == spdif_in_pkg::FMT_LEFT |=> st_q == ST_SHIFT && got_q == 5'h1)
    else $error("left-justified MSB not taken at transition");
  a_i2s_wait: assert property (@(posedge clock) disable iff (rst)
    fs_edge && fmt == spdif_in_pkg::FMT_I2S |=> st_q == ST_WAIT && cnt_q == 6'h0)
    else $error("I2S delay wrong");
  a_rj_delay: assert property (@(posedge clock) disable iff (rst)
    fs_edge && fmt == spdif_in_pkg::FMT_RIGHT && width == spdif_in_pkg::W16
    |=> cnt_q == 6'h0f)
    else $error("right-justified delay wrong");
  // I2S low frame sync is left
  a_i2s_chan: assert property (@(posedge clock) disable iff (rst)
    fs_edge && fmt == spdif_in_pkg::FMT_I2S |=> chan_q == $past(fs_s))
    else $error("I2S channel wrong");
  // RJ high frame sync is left
  a_rj_chan: assert property (@(posedge clock) disable iff (rst)
    fs_edge && fmt == spdif_in_pkg::FMT_RIGHT |=> chan_q == !$past(fs_s))
    else $error("RJ channel wrong");
  // LJ high frame sync is left
  a_lj_chan: assert property (@(posedge clock) disable iff (rst)
    fs_edge && fmt == spdif_in_pkg::FMT_LEFT |=> chan_q == !$past(fs_s))
    else $error("LJ channel wrong");
  a_bit_count: assert property (@(posedge clock) disable iff (rst)
    got_q <= nbits)
    else $error("too many bits");
  // shift only on serial clock rise
  a_shift_edge: assert property (@(posedge clock) disable iff (rst)
    st_q == ST_SHIFT && got_q != $past(got_q) && got_q != 5'h0 |-> $past(sclk_rise))
    else $error("bit taken without clock edge");
endmodule : spdif_serial_in
`default_nettype wire

// File: sim/audio_source.sv
// Behavioural serial audio source that feeds the input stage one channel slot at a time.
// Assumes the 100 MHz system clock; the serial clock is 8 system clocks long.
`default_nettype none
module audio_source (
  input  wire logic                        clock,
  input  wire spdif_in_pkg::frame_fmt_t    fmt,
  input  wire spdif_in_pkg::word_width_t   width,
  output logic                             serial_clock,
  output logic                             frame_sync,
  output logic                             serial_data
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////////
  // Idle levels; serial clock stands still between slots
  initial
  begin
    serial_clock = 1'b0;
    frame_sync   = 1'b0;
    serial_data  = 1'b0;
  end
  function automatic int nbits(input spdif_in_pkg::word_width_t w);
    return (w == spdif_in_pkg::W24) ? 24 : 16 + 2 * int'(w);
  endfunction : nbits
  //////////////////////////////////////////////////////////////////////////////
  // One 32-clock slot; frame sync toggles so every slot opens on a transition
  task automatic send_slot(input logic [23:0] word);
    int   n;
    int   d;
    n = nbits(width);
    case (fmt)
      spdif_in_pkg::FMT_LEFT: d = 0;
      spdif_in_pkg::FMT_I2S:  d = 1;
      default:                d = (n == 16) ? 16 : (n == 18) ? 14 : (n == 20) ? 12 : 8;
    endcase
    for (int k = 0; k < 32; k++)
    begin
      @(posedge clock);
      serial_clock <= 1'b0;
      if (k == 0)
        frame_sync <= ~frame_sync;
      // MSB first; filler bits flip so stale data never looks valid
      serial_data <= (k >= d && k < d + n) ? word[23 - (k - d)] : ~serial_data;
      repeat (4) @(posedge clock);
      // data settled well before the rising edge
      serial_clock <= 1'b1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    serial_clock <= 1'b0;
    serial_data  <= ~serial_data;
  endtask : send_slot
endmodule : audio_source
`default_nettype wire

// File: sim/test_spdif_serial_in.sv
// Self-checking bench for the serial audio input stage.
// Assumes the audio source model drives the link and the bench consumes words.
`default_nettype none
module test_spdif_serial_in;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clock;
  logic                       rst;
  logic                       serial_clock;
  logic                       frame_sync;
  logic                       serial_data;
  logic                       oversample_tx_clock;
  spdif_in_pkg::frame_fmt_t   fmt;
  spdif_in_pkg::word_width_t  width;
  logic                       osr_384;
  logic                       sample_valid;
  logic                       sample_ready;
  logic                       sample_right;
  logic [23:0]                sample_data;
  logic                       biphase_tick;
  logic                       overrun;
  int                         errors;
  int                         num_checks;
  logic [24:0]                exp_q[$];
  //////////////////////////////////////////////////////////////////////////////
  // Instances and clock
  audio_source source_u (.clock(clock), .fmt(fmt), .width(width), .serial_clock(serial_clock),
    .frame_sync(frame_sync), .serial_data(serial_data));
  spdif_serial_in dut_u (.clock(clock), .rst(rst), .serial_clock(serial_clock), .frame_sync(frame_sync),
    .serial_data(serial_data), .oversample_tx_clock(oversample_tx_clock), .fmt(fmt), .width(width),
    .osr_384(osr_384), .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_right(sample_right),
    .sample_data(sample_data), .biphase_tick(biphase_tick), .overrun(overrun));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Every accepted word must match the oldest expected one; strays meet an unknown
  always @(posedge clock)
    if (!rst && sample_valid === 1'b1 && sample_ready === 1'b1)
      check("word", {sample_right, sample_data}, exp_q.size() ? exp_q.pop_front() : 25'hx);
  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check("valid", 25'(sample_valid), 25'h0);
    check("overrun", 25'(overrun), 25'h0);
    check("data", 25'(sample_data), 25'h0);
    check("tick", 25'(biphase_tick), 25'h0);
  endtask : do_reset
  // Expectation goes in first: short words can land before the slot ends
  task automatic send(input logic [23:0] word, input bit kept);
    if (kept)
      exp_q.push_back({(fmt == spdif_in_pkg::FMT_I2S) ? ~frame_sync : frame_sync,
        word & (24'hffffff << (24 - source_u.nbits(width)))});
    source_u.send_slot(word);
  endtask : send
  task automatic drain;
    for (int i = 0; i < 60 && exp_q.size() != 0; i++)
      @(posedge clock);
    check("pending words", 25'(exp_q.size()), 25'h0);
  endtask : drain
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic tick_count(input logic sel, input int exp);
    int seen;
    @(posedge clock);
    osr_384 <= sel;
    do_reset();
    seen = 0;
    for (int i = 0; i < 112; i++)
    begin
      @(posedge clock);
      if (i < 96)
        oversample_tx_clock <= (i % 8) < 4;
      if (biphase_tick === 1'b1)
        seen++;
    end
    check("tick count", 25'(seen), 25'(exp));
  endtask : tick_count
  task automatic format_sweep;
    for (int f = 0; f < 3; f++)
      for (int w = 0; w < 4; w++)
      begin
        @(posedge clock);
        fmt   <= spdif_in_pkg::frame_fmt_t'(f);
        width <= spdif_in_pkg::word_width_t'(w);
        @(posedge clock);
        send(24'hc3a5e1 ^ {f[3:0], w[3:0], 16'h0}, 1'b1);
        send(24'h5b2d87 ^ {16'h0, w[3:0], f[3:0]}, 1'b1);
        drain();
      end
  endtask : format_sweep
  // Consumer stalls: two words fit, the third is dropped and flagged
  task automatic stall_overrun;
    @(posedge clock);
    sample_ready <= 1'b0;
    send(24'h123456, 1'b1);
    send(24'hfedcba, 1'b1);
    check("overrun early", 25'(overrun), 25'h0);
    send(24'h0f0f0f, 1'b0);
    for (int i = 0; i < 40 && overrun !== 1'b1; i++)
      @(posedge clock);
    check("overrun", 25'(overrun), 25'h1);
    check("valid held", 25'(sample_valid), 25'h1);
    sample_ready <= 1'b1;
    drain();
  endtask : stall_overrun
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog, about four times the expected run length
  initial
  begin
    #300us;
    errors++;
    close_out();
  end
  // Main sequence
  initial
  begin
    rst                 = 1'b1;
    fmt                 = spdif_in_pkg::FMT_I2S;
    width               = spdif_in_pkg::W16;
    osr_384             = 1'b0;
    oversample_tx_clock = 1'b0;
    sample_ready        = 1'b1;
    errors              = 0;
    num_checks          = 0;
    tick_count(1'b0, 6);
    tick_count(1'b1, 4);
    format_sweep();
    stall_overrun();
    do_reset();
    close_out();
  end
endmodule : test_spdif_serial_in
`default_nettype wire
